// ==== hw/dcc_pkg.sv ====
package dcc_pkg;
    // ==========================================
    // register indices on the access port
    localparam logic [3:0] IDX_STATE = 4'h0;
    localparam logic [3:0] IDX_CMD = 4'h1;
    localparam logic [3:0] IDX_FAULT = 4'h2;
    localparam logic [3:0] IDX_CFG = 4'h3;
    localparam logic [3:0] IDX_BCNT = 4'h4;
    localparam logic [3:0] IDX_BASECNT = 4'h5;
    localparam logic [3:0] IDX_MPTR = 4'h6;
    localparam logic [3:0] IDX_DPTR = 4'h7;
    localparam logic [3:0] IDX_BASEADR = 4'h8;
    localparam logic [3:0] IDX_FC = 4'h9;
    // ==========================================
    // state register bit positions
    localparam int B_FIN = 7;
    localparam int B_BDONE = 6;
    localparam int B_PTERM = 5;
    localparam int B_FAULT = 4;
    localparam int B_RUN = 3;
    localparam int B_FELL = 1;
    localparam int B_LEVEL = 0;
    // command register bit positions
    localparam int B_START = 7;
    localparam int B_CONT = 6;
    localparam int B_HALT = 5;
    localparam int B_KILL = 4;
    localparam int B_PERMIT = 3;
    // ==========================================
    // fault codes
    localparam logic [7:0] FC_CONFIG = 8'h01;
    localparam logic [7:0] FC_TIMING = 8'h02;
    localparam logic [7:0] FC_BUS = 8'h09;
    localparam logic [7:0] FC_COUNT = 8'h0D;
    localparam logic [7:0] FC_ABORT = 8'h11;
    localparam logic [7:0] RST_BYTE = 8'h00;
    // operand sizes, count directions, chain modes
    localparam logic [1:0] SZ_BYTE = 2'h0;
    localparam logic [1:0] SZ_WORD = 2'h1;
    localparam logic [1:0] SZ_LONG = 2'h2;
    localparam logic [1:0] DIR_UP = 2'h1;
    localparam logic [1:0] DIR_DOWN = 2'h2;
    localparam logic [1:0] CH_NONE = 2'h0;
    localparam logic [1:0] CH_ARRAY = 2'h2;
    // ==========================================
    // decoded configuration register
    typedef struct packed {
        logic pcl_irq;
        logic burst;
        logic [1:0] chain;
        logic [1:0] ddir;
        logic [1:0] mdir;
        logic pack;
        logic port16;
        logic [1:0] size;
    } dcc_cfg_t;
    // device write carrier
    typedef struct packed {
        logic [31:0] addr;
        logic [15:0] data;
    } dcc_dev_t;
endpackage

// ==== hw/dcc_channel.sv ====
`timescale 1ns/1ns

// ==========================================
// small synchronous fifo
module dcc_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic flush,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH]; // word store
    logic [AW-1:0] wp_q, rp_q; // pointers
    logic [AW:0] cnt_q; // fill level
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    assign in_ready = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data = mem_q[rp_q];
    // pointers and level
    always_ff @(posedge ref_clk) begin
        if (!rst_b || flush) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) wp_q <= wp_q + 1'b1;
            if (pop) rp_q <= rp_q + 1'b1;
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
    // storage needs no reset
    always_ff @(posedge ref_clk) begin
        if (push) mem_q[wp_q] <= in_data;
    end
endmodule

// ==========================================
// channel control, status and operand mover
module dcc_channel import dcc_pkg::*; #(
    parameter int FIFO_DEPTH = 8
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // register access port
    input wire logic reg_wr,
    input wire logic [3:0] reg_idx,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    // memory read side
    output logic mem_rd,
    output logic [31:0] mem_addr,
    output logic [2:0] mem_fc,
    input wire logic mem_ack,
    input wire logic mem_err,
    input wire logic [15:0] mem_rdata,
    // device write side
    output logic dev_wr,
    output dcc_dev_t dev_out,
    input wire logic dev_ack,
    input wire logic dev_err,
    // peripheral lines
    input wire logic xfer_req,
    input wire logic periph_done,
    input wire logic peripheral_control_pin,
    output logic done_pulse,
    output logic irq
);
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_MOVE = 2'b01,
        ST_END = 2'b11
    } dcc_st_t;
    // ==========================================
    // storage
    dcc_st_t st_q;
    logic [7:0] state_q, fault_code_reg, rdata_d;
    logic start_request, continue_block_flag, halt_q, soft_kill, permit_q;
    dcc_cfg_t cfg_q;
    logic [15:0] block_count_reg, base_cnt_q, holding_latch;
    logic [31:0] memory_pointer, device_pointer, base_adr_q;
    logic [2:0] fc_q, base_fc_q;
    logic pend_q, req_q, done_q;
    logic [2:0] fetch_left, drain_left; // parts still to move
    logic [1:0] byte_left; // bytes left in latch
    logic [1:0] pcl_hist; // last two pin samples
    // ==========================================
    // address step, signed by count direction
    function automatic logic [31:0] stepped(input logic [31:0] a, input logic [1:0] dir,
                                            input logic [1:0] amt);
        logic [31:0] s;
        s = {30'h0, amt};
        case (dir)
            DIR_UP: stepped = a + s;
            DIR_DOWN: stepped = a - s;
            default: stepped = a;
        endcase
    endfunction
    // ==========================================
    // decode
    wire wr_state = reg_wr && reg_idx == IDX_STATE;
    wire wr_cmd = reg_wr && reg_idx == IDX_CMD;
    wire is_byte = cfg_q.size == SZ_BYTE;
    wire is_long = cfg_q.size == SZ_LONG;
    wire busy_flags = |state_q[B_FIN:B_RUN];
    wire cfg_bad = cfg_q.size == 2'h3 || cfg_q.chain == 2'h1 || cfg_q.ddir == 2'h3
        || cfg_q.mdir == 2'h3;
    wire cnt_bad = block_count_reg == '0 || (cfg_q.chain == CH_ARRAY && base_cnt_q == '0);
    wire running = state_q[B_RUN];
    // memory always 16-bit: word parts step 2, bytes step P
    wire [1:0] p_step = cfg_q.pack ? 2'd2 : 2'd1;
    wire [1:0] m_step = is_byte ? p_step : 2'd2;
    wire [1:0] d_step = (!cfg_q.port16 || !is_byte) ? 2'd2 : p_step;
    wire [2:0] m_parts = is_long ? 3'd2 : 3'd1;
    wire [2:0] d_parts = cfg_q.port16 ? m_parts : (is_byte ? 3'd1 : (is_long ? 3'd4 : 3'd2));
    wire [1:0] bytes_per_word = (!cfg_q.port16 && !is_byte) ? 2'd2 : 2'd1;
    // start and continue handling on a command write
    wire start_w = wr_cmd && reg_wdata[B_START];
    wire cont_w = wr_cmd && reg_wdata[B_CONT];
    wire start_err = start_request && (busy_flags || cfg_bad || cnt_bad);
    wire start_ok = start_request && !start_err;
    wire cont_late = cont_w && !start_w && (!running || state_q[B_BDONE]);
    wire cont_chain = cont_w && cfg_q.chain != CH_NONE;
    wire kill = wr_cmd && reg_wdata[B_KILL] && running;
    // ==========================================
    // fifo and mover handshakes
    logic fifo_in_ready, fifo_out_valid;
    logic [15:0] fifo_out;
    wire moving = st_q == ST_MOVE;
    assign mem_rd = moving && fetch_left != '0 && fifo_in_ready;
    assign dev_wr = moving && byte_left != '0;
    wire pop = moving && byte_left == '0 && drain_left != '0 && fifo_out_valid;
    wire bus_err = (mem_rd && mem_err) || (dev_wr && dev_err);
    wire pterm = dev_wr && periph_done;
    wire abort = moving && (bus_err || pterm);
    wire have_req = cfg_q.burst ? xfer_req : pend_q;
    wire go = st_q == ST_IDLE && running && !halt_q && have_req && !kill;
    wire [15:0] cnt_next = block_count_reg - 16'h1;
    wire blk_end = st_q == ST_END && cnt_next == '0;
    wire do_cont = blk_end && continue_block_flag;
    wire fell = pcl_hist == 2'b10 && !peripheral_control_pin;
    assign mem_addr = memory_pointer;
    assign mem_fc = fc_q;
    assign dev_out = '{addr: device_pointer, data: holding_latch};
    assign done_pulse = done_q;
    assign irq = permit_q && (|state_q[B_FIN:B_FAULT] || (cfg_q.pcl_irq && state_q[B_FELL]));
    dcc_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_fifo (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .flush(!moving),
        .in_valid(mem_rd && mem_ack && !mem_err),
        .in_ready(fifo_in_ready),
        .in_data(mem_rdata),
        .out_valid(fifo_out_valid),
        .out_ready(pop),
        .out_data(fifo_out)
    );
    // ==========================================
    // next state flags: event sets win over clears
    logic [7:0] st_d, code_d;
    always_comb begin
        st_d = state_q;
        code_d = fault_code_reg;
        if (wr_state) st_d[7:1] = state_q[7:1] & ~{reg_wdata[7:4], 1'b0, reg_wdata[2:1]};
        st_d[B_LEVEL] = peripheral_control_pin;
        if (fell) st_d[B_FELL] = 1'b1;
        if (start_ok) st_d[B_RUN] = 1'b1;
        if (start_err || cont_late || cont_chain) st_d[B_FAULT] = 1'b1;
        if (start_err) code_d = busy_flags ? FC_TIMING : (cfg_bad ? FC_CONFIG : FC_COUNT);
        if (cont_chain) code_d = FC_CONFIG;
        else if (cont_late) code_d = FC_TIMING;
        if (kill) begin
            st_d[B_FAULT] = 1'b1;
            st_d[B_FIN] = 1'b1;
            st_d[B_RUN] = 1'b0;
            code_d = FC_ABORT;
        end
        if (abort) begin
            st_d[B_RUN] = 1'b0;
            st_d[B_FIN] = 1'b1;
            if (pterm) st_d[B_PTERM] = 1'b1;
            if (bus_err) begin
                st_d[B_FAULT] = 1'b1;
                code_d = FC_BUS;
            end
        end
        if (blk_end && !do_cont) begin
            st_d[B_RUN] = 1'b0;
            st_d[B_FIN] = 1'b1;
        end
        if (do_cont) begin
            st_d[B_BDONE] = 1'b1;
            if (base_cnt_q == '0) begin
                st_d[B_FAULT] = 1'b1;
                st_d[B_FIN] = 1'b1;
                st_d[B_RUN] = 1'b0;
                code_d = FC_COUNT;
            end
        end
    end
    // ==========================================
    // flags, command and fault code
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            state_q <= RST_BYTE;
            fault_code_reg <= RST_BYTE;
            start_request <= 1'b0;
            continue_block_flag <= 1'b0;
            halt_q <= 1'b0;
            soft_kill <= 1'b0;
            permit_q <= 1'b0;
            pcl_hist <= 2'b11;
        end else begin
            state_q <= st_d;
            fault_code_reg <= code_d;
            pcl_hist <= {pcl_hist[0], peripheral_control_pin};
            start_request <= start_w;
            if (wr_cmd) begin
                halt_q <= reg_wdata[B_HALT];
                permit_q <= reg_wdata[B_PERMIT];
            end
            if (cont_w && !cont_late && !cont_chain) continue_block_flag <= 1'b1;
            else if (do_cont) continue_block_flag <= 1'b0;
            if (kill) soft_kill <= 1'b1;
            else if (!st_d[B_FAULT]) soft_kill <= 1'b0;
        end
    end
    // ==========================================
    // software-loaded setup registers
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            cfg_q <= '0;
            base_cnt_q <= '0;
            base_adr_q <= '0;
            base_fc_q <= '0;
        end else if (reg_wr) begin
            if (reg_idx == IDX_CFG) cfg_q <= reg_wdata[$bits(dcc_cfg_t)-1:0];
            if (reg_idx == IDX_BASECNT) base_cnt_q <= reg_wdata[15:0];
            if (reg_idx == IDX_BASEADR) base_adr_q <= reg_wdata;
            if (reg_idx == IDX_FC) base_fc_q <= reg_wdata[6:4];
        end
    end
    // ==========================================
    // pointers and block count; hardware moves win over writes
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            memory_pointer <= '0;
            device_pointer <= '0;
            block_count_reg <= '0;
            fc_q <= '0;
        end else begin
            if (reg_wr && reg_idx == IDX_MPTR) memory_pointer <= reg_wdata;
            if (reg_wr && reg_idx == IDX_DPTR) device_pointer <= reg_wdata;
            if (reg_wr && reg_idx == IDX_BCNT) block_count_reg <= reg_wdata[15:0];
            if (reg_wr && reg_idx == IDX_FC) fc_q <= reg_wdata[2:0];
            if (mem_rd && mem_ack && !mem_err)
                memory_pointer <= stepped(memory_pointer, cfg_q.mdir, m_step);
            if (dev_wr && dev_ack && !dev_err)
                device_pointer <= stepped(device_pointer, cfg_q.ddir, d_step);
            if (st_q == ST_END) block_count_reg <= cnt_next;
            if (do_cont) begin
                memory_pointer <= base_adr_q;
                fc_q <= base_fc_q;
                block_count_reg <= base_cnt_q;
            end
        end
    end
    // ==========================================
    // operand sequencer
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            st_q <= ST_IDLE;
            fetch_left <= '0;
            drain_left <= '0;
        end else begin
            case (st_q)
                ST_IDLE: if (go) begin
                    st_q <= ST_MOVE;
                    fetch_left <= m_parts;
                    drain_left <= d_parts;
                end
                ST_MOVE: begin
                    if (mem_rd && mem_ack) fetch_left <= fetch_left - 3'd1;
                    if (dev_wr && dev_ack) drain_left <= drain_left - 3'd1;
                    if (abort || kill) st_q <= ST_IDLE;
                    else if (dev_wr && dev_ack && drain_left == 3'd1) st_q <= ST_END;
                end
                ST_END: st_q <= ST_IDLE;
                default: st_q <= ST_IDLE;
            endcase
        end
    end
    // ==========================================
    // holding latch: upper byte goes out first
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            holding_latch <= '0;
            byte_left <= '0;
        end else if (!moving) begin
            byte_left <= '0;
        end else if (pop) begin
            holding_latch <= (!cfg_q.port16 && is_byte) ? {fifo_out[7:0], 8'h00} : fifo_out;
            byte_left <= bytes_per_word;
        end else if (dev_wr && dev_ack) begin
            holding_latch <= {holding_latch[7:0], 8'h00};
            byte_left <= byte_left - 2'd1;
        end
    end
    // ==========================================
    // requests, done strobe, read data
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            pend_q <= 1'b0;
            req_q <= 1'b0;
            done_q <= 1'b0;
            reg_rdata <= '0;
        end else begin
            req_q <= xfer_req;
            // request edges are kept even while halted
            if (start_ok) pend_q <= 1'b0;
            else if (xfer_req && !req_q) pend_q <= 1'b1;
            else if (go) pend_q <= 1'b0;
            done_q <= blk_end;
            reg_rdata <= {24'h0, rdata_d};
        end
    end
    // read mux; cfg, count and pointer registers show their low byte, base and FC registers read zero
    always_comb begin
        case (reg_idx)
            IDX_STATE: rdata_d = state_q;
            IDX_CMD: rdata_d = {start_request, continue_block_flag, halt_q, 1'b0, permit_q,
                3'h0};
            IDX_FAULT: rdata_d = fault_code_reg;
            IDX_CFG: rdata_d = cfg_q[7:0];
            IDX_BCNT: rdata_d = block_count_reg[7:0];
            IDX_MPTR: rdata_d = memory_pointer[7:0];
            IDX_DPTR: rdata_d = device_pointer[7:0];
            default: rdata_d = RST_BYTE;
        endcase
    end
    // ==========================================
    // checks
    a_start_runs: assert property (@(posedge ref_clk) disable iff (!rst_b)
        start_ok |=> state_q[B_RUN] && !start_request && !pend_q)
        else $error("start did not activate channel");
    a_busy_timing: assert property (@(posedge ref_clk) disable iff (!rst_b)
        start_request && busy_flags |=> state_q[B_FAULT] && fault_code_reg == FC_TIMING)
        else $error("busy start not refused");
    a_kill_abort: assert property (@(posedge ref_clk) disable iff (!rst_b)
        kill |=> !state_q[B_RUN] && state_q[B_FIN] && fault_code_reg == FC_ABORT)
        else $error("soft kill did not abort");
    a_halt_quiet: assert property (@(posedge ref_clk) disable iff (!rst_b)
        halt_q && st_q == ST_IDLE |=> st_q == ST_IDLE)
        else $error("halted channel moved");
    a_irq_gate: assert property (@(posedge ref_clk) disable iff (!rst_b)
        !permit_q |-> !irq)
        else $error("interrupt without permit");
    a_done_block: assert property (@(posedge ref_clk) disable iff (!rst_b)
        do_cont |=> done_pulse && state_q[B_BDONE] && !continue_block_flag)
        else $error("continuation missed done");
    a_fell_flag: assert property (@(posedge ref_clk) disable iff (!rst_b)
        $fell(pcl_hist[1]) && !pcl_hist[0] && !peripheral_control_pin |=> state_q[B_FELL])
        else $error("line fall not flagged");
    a_w1c_keep: assert property (@(posedge ref_clk) disable iff (!rst_b)
        wr_state && reg_wdata[B_FIN] == 1'b0 && state_q[B_FIN] |=> state_q[B_FIN])
        else $error("zero write cleared flag");
    a_long_step: assert property (@(posedge ref_clk) disable iff (!rst_b)
        mem_rd && mem_ack && !mem_err && cfg_q.mdir == DIR_UP && !is_byte
        |=> memory_pointer == $past(memory_pointer) + 32'h2 || do_cont)
        else $error("memory part step not two");
endmodule

// ==== tb/dcc_far_model.sv ====
`timescale 1ns/1ns
// ==========================================
// memory and device responders on the far side
module dcc_far_model import dcc_pkg::*; (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // behaviour knobs
    input wire logic [15:0] key,
    input wire logic slow,
    input wire logic bad,
    // memory side
    input wire logic mem_rd,
    input wire logic [31:0] mem_addr,
    output logic mem_ack,
    output logic mem_err,
    output logic [15:0] mem_rdata,
    // device side
    input wire logic dev_wr,
    input wire dcc_dev_t dev_out,
    output logic dev_ack,
    output logic dev_err,
    // observation
    output logic [7:0] n_rd,
    output logic [7:0] n_wr,
    output logic [31:0] cap
);
    logic [1:0] mw, dw; // wait counters
    wire [1:0] wt = slow ? 2'h3 : 2'h0; // slow answers take three extra cycles
    wire m_go = mem_rd && !mem_ack && (mw >= wt);
    wire d_go = dev_wr && !dev_ack && (dw >= wt);
    assign mem_err = mem_ack & bad; // bus error rides on the ack
    assign dev_err = 1'b0;
    // ==========================================
    // one ack pulse per request; data toggles when not valid
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            {mem_ack, dev_ack, mw, dw, n_rd, n_wr, cap, mem_rdata} <= '0;
        end else begin
            mem_ack <= m_go;
            dev_ack <= d_go;
            mw <= (mem_rd && !mem_ack && !m_go) ? mw + 2'h1 : 2'h0;
            dw <= (dev_wr && !dev_ack && !d_go) ? dw + 2'h1 : 2'h0;
            mem_rdata <= m_go ? (mem_addr[15:0] ^ key) : ~mem_rdata;
            if (m_go) n_rd <= n_rd + 8'h01;
            if (d_go) begin
                n_wr <= n_wr + 8'h01;
                cap <= {cap[23:0], dev_out.data[15:8]}; // 8-bit port byte lane
            end
        end
    end
endmodule

// ==== tb/test_dcc_channel.sv ====
`timescale 1ns/1ns
// ==========================================
// channel control and status bench
module test_dcc_channel import dcc_pkg::*; ;
    logic ref_clk = 0, rst_b = 0, reg_wr = 0, xfer_req = 0, pin = 1, slow = 0, bad = 0;
    logic pdone = 0; // peripheral done line
    logic [3:0] reg_idx = 4'h0;
    logic [31:0] reg_wdata = '0, reg_rdata, mem_addr, cap;
    logic mem_rd, mem_ack, mem_err, dev_wr, dev_ack, dev_err, done_pulse, irq;
    logic [2:0] mem_fc;
    logic [15:0] mem_rdata, key = 16'h0000;
    logic [7:0] n_rd, n_wr, v, r0;
    dcc_dev_t dev_out;
    int err_count = 0, checks = 0, ndone = 0;
    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (done_pulse === 1'b1) ndone++;
    dcc_channel #(.FIFO_DEPTH(8)) i_dut (.ref_clk(ref_clk), .rst_b(rst_b), .reg_wr(reg_wr),
        .reg_idx(reg_idx), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .mem_rd(mem_rd),
        .mem_addr(mem_addr), .mem_fc(mem_fc), .mem_ack(mem_ack), .mem_err(mem_err),
        .mem_rdata(mem_rdata), .dev_wr(dev_wr), .dev_out(dev_out), .dev_ack(dev_ack),
        .dev_err(dev_err), .xfer_req(xfer_req), .periph_done(pdone),
        .peripheral_control_pin(pin), .done_pulse(done_pulse), .irq(irq));
    dcc_far_model i_far (.ref_clk(ref_clk), .rst_b(rst_b), .key(key), .slow(slow), .bad(bad),
        .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_err(mem_err),
        .mem_rdata(mem_rdata), .dev_wr(dev_wr), .dev_out(dev_out), .dev_ack(dev_ack),
        .dev_err(dev_err), .n_rd(n_rd), .n_wr(n_wr), .cap(cap));
    // ==========================================
    // expected device bytes of the second long operand
    function automatic logic [31:0] exp_cap(input logic [15:0] k);
        return {16'h0016 ^ k, 16'h0018 ^ k};
    endfunction
    task automatic summarize;
        $display("counts: checks %0d errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one-cycle write strobe, released on the following edge
    task automatic wr(input logic [3:0] i, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_idx <= i;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    // read data is registered, so look after the second edge
    task automatic chk(input logic [3:0] i, input logic [7:0] e);
        @(posedge ref_clk);
        reg_idx <= i;
        repeat (2) @(posedge ref_clk);
        #1 cmp({24'h0, reg_rdata[7:0]}, {24'h0, e});
    endtask
    // bounded poll of the finished flag
    task automatic wait_fin;
        for (int n = 0; n < 300; n++) begin
            @(posedge ref_clk);
            reg_idx <= IDX_STATE;
            repeat (2) @(posedge ref_clk);
            #1 if (reg_rdata[B_FIN] === 1'b1) return;
        end
        err_count++;
        summarize();
    endtask
    // program and start one run, long-to-8-bit unless c gives another config
    task automatic run(input logic [7:0] cnt, input logic [7:0] cmd,
                       input logic [31:0] c = 32'h452);
        wr(IDX_CFG, c); // default long, 8-bit port, up/up, burst
        wr(IDX_BCNT, {24'h0, cnt});
        wr(IDX_MPTR, 32'h12);
        wr(IDX_DPTR, 32'h108);
        wr(IDX_CMD, {24'h0, cmd});
    endtask
    initial begin
        void'($urandom(32'h92CD));
        repeat (4) @(posedge ref_clk);
        rst_b <= 1'b1;
        // burst request held through halts
        xfer_req <= 1'b1;
        chk(IDX_STATE, 8'h01);
        chk(IDX_CMD, 8'h00);
        $display("reset test done");
        run(8'h00, 8'h80);
        chk(IDX_FAULT, FC_COUNT);
        wr(IDX_STATE, 32'hFF);
        chk(IDX_STATE, 8'h01);
        wr(IDX_CFG, 32'h453);
        wr(IDX_CMD, 32'h80);
        chk(IDX_FAULT, FC_CONFIG);
        wr(IDX_STATE, 32'hFF);
        $display("start error tests done");
        wr(IDX_CFG, 32'h652); // array chaining
        wr(IDX_CMD, 32'h40);
        chk(IDX_FAULT, FC_CONFIG);
        wr(IDX_STATE, 32'hFF);
        wr(IDX_CFG, 32'h452);
        wr(IDX_CMD, 32'h40);
        chk(IDX_FAULT, FC_TIMING);
        wr(IDX_STATE, 32'hFF);
        $display("continue refusal tests done");
        for (int t = 0; t < 3; t++) begin
            key <= 16'($urandom);
            slow <= t[0];
            r0 = n_rd;
            v = n_wr;
            ndone = 0;
            run(8'h02, 8'h88);
            wait_fin();
            cmp({24'h0, n_rd - r0}, 32'h4);
            cmp({24'h0, n_wr - v}, 32'h8);
            cmp(cap, exp_cap(key));
            cmp(ndone, 32'h1);
            chk(IDX_MPTR, 8'h1A);
            chk(IDX_DPTR, 8'h18);
            chk(IDX_STATE, 8'h81);
            cmp({31'h0, irq}, 32'h1);
            wr(IDX_CMD, 32'h00);
            #1 cmp({31'h0, irq}, 32'h0);
            wr(IDX_CMD, 32'h80);
            chk(IDX_FAULT, FC_TIMING);
            wr(IDX_STATE, 32'hFF);
            $display("transfer test %0d done", t);
        end
        r0 = n_rd;
        run(8'h05, 8'hA0);
        repeat (20) @(posedge ref_clk);
        cmp({24'h0, n_rd}, {24'h0, r0});
        wr(IDX_CMD, 32'h30);
        chk(IDX_FAULT, FC_ABORT);
        chk(IDX_STATE, 8'h91);
        chk(IDX_CMD, 8'h20);
        wr(IDX_STATE, 32'hFF);
        wr(IDX_CMD, 32'h00);
        $display("halt and kill test done");
        bad <= 1'b1;
        run(8'h02, 8'h80);
        wait_fin();
        chk(IDX_FAULT, FC_BUS);
        chk(IDX_STATE, 8'h91);
        bad <= 1'b0;
        wr(IDX_STATE, 32'hFF);
        $display("bus error test done");
        pdone <= 1'b1;
        run(8'h02, 8'h80);
        wait_fin();
        chk(IDX_STATE, 8'hA1);
        wr(IDX_STATE, 32'hFF);
        pdone <= 1'b0;
        $display("peripheral done test done");
        ndone = 0;
        wr(IDX_BASECNT, 32'h1);
        wr(IDX_FC, 32'h50);
        wr(IDX_BASEADR, 32'h40);
        run(8'h01, 8'hC0);
        wait_fin();
        chk(IDX_STATE, 8'hC1);
        chk(IDX_MPTR, 8'h44);
        chk(IDX_CMD, 8'h00);
        cmp(ndone, 32'h2);
        cmp({29'h0, mem_fc}, 32'h5);
        wr(IDX_STATE, 32'hFF);
        $display("continue test done");
        wr(IDX_BASECNT, 32'h0);
        run(8'h01, 8'hC0);
        wait_fin();
        chk(IDX_FAULT, FC_COUNT);
        chk(IDX_STATE, 8'hD1);
        wr(IDX_STATE, 32'hFF);
        for (int p = 0; p < 2; p++) begin
            xfer_req <= 1'b0; // cycle steal: one rising edge per operand
            run(8'h01, 8'h80, p[0] ? 32'h05C : 32'h054);
            @(posedge ref_clk);
            xfer_req <= 1'b1;
            wait_fin();
            chk(IDX_MPTR, p[0] ? 8'h14 : 8'h13);
            chk(IDX_DPTR, p[0] ? 8'h0A : 8'h09);
            wr(IDX_STATE, 32'hFF);
        end
        $display("count and packing tests done");
        @(posedge ref_clk);
        pin <= 1'b0;
        repeat (3) @(posedge ref_clk);
        pin <= 1'b1;
        chk(IDX_STATE, 8'h03);
        $display("line test done");
        summarize();
    end
endmodule
